/* mult_pkg.sv */
// shared widths, reset values, source selection and control carrier for the multiplier
package mult_pkg;
    localparam int OPERAND_W = 18;
    localparam int RESULT_W = 36;
    localparam logic [OPERAND_W-1:0] OPERAND_RESET = 18'h00000;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 36'h000000000;
    localparam int STAGE_COUNT = 3;
    // stage indices into the control arrays
    localparam int STG_OP_ONE = 0;
    localparam int STG_OP_TWO = 1;
    localparam int STG_RESULT = 2;
    // default: every stage inserted
    localparam bit STAGE_IN_DEFAULT = 1'b1;

    typedef enum logic {
        LOCAL_SOURCE,
        CHAIN_SOURCE
    } src_sel_t;

    typedef struct packed {
        logic load_enable;
        logic clear;
    } stage_ctrl_t;
endpackage : mult_pkg

/* pipelined_signed_multiplier.sv */
// signed 18x18 multiplier with optional operand and result stages and operand cascade
`timescale 1ns/1ps

module pipelined_signed_multiplier
    import mult_pkg::*;
#(
    parameter int OP_W = OPERAND_W,
    parameter int RES_W = RESULT_W,
    parameter bit OPERAND_ONE_STAGE = STAGE_IN_DEFAULT,
    parameter bit OPERAND_TWO_STAGE = STAGE_IN_DEFAULT,
    parameter bit RESULT_STAGE = STAGE_IN_DEFAULT,
    parameter src_sel_t SECOND_SOURCE = LOCAL_SOURCE,
    parameter bit CLK_INVERT = 1'b0,
    parameter logic [STAGE_COUNT-1:0] LOAD_INVERT = 3'h0,
    parameter logic [STAGE_COUNT-1:0] CLEAR_INVERT = 3'h0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // operands
    input wire logic [OP_W-1:0] operand_one,
    input wire logic [OP_W-1:0] operand_two,
    input wire logic [OP_W-1:0] chained_operand_in,
    // stage controls
    input wire logic operand_one_load_enable,
    input wire logic operand_one_clear,
    input wire logic operand_two_load_enable,
    input wire logic operand_two_clear,
    input wire logic result_load_enable,
    input wire logic result_clear,
    // results
    output logic [RES_W-1:0] result_word,
    output logic [OP_W-1:0] chained_operand_out
);
    logic stage_clk;
    stage_ctrl_t ctrl_raw [STAGE_COUNT];
    stage_ctrl_t ctrl [STAGE_COUNT];
    logic [OP_W-1:0] operand_one_reg;
    logic [OP_W-1:0] operand_one_next;
    logic [OP_W-1:0] operand_two_reg;
    logic [OP_W-1:0] operand_two_next;
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] result_next;
    logic [OP_W-1:0] second_src;
    logic [OP_W-1:0] op_one_val;
    logic [OP_W-1:0] op_two_val;
    logic signed [RES_W-1:0] mult_out;

    // inverting the clock moves every stage to the falling edge together
    assign stage_clk = core_clk ^ CLK_INVERT;

    assign ctrl_raw[STG_OP_ONE] = '{operand_one_load_enable, operand_one_clear};
    assign ctrl_raw[STG_OP_TWO] = '{operand_two_load_enable, operand_two_clear};
    assign ctrl_raw[STG_RESULT] = '{result_load_enable, result_clear};

    generate
        for (genvar i = 0; i < STAGE_COUNT; i++) begin : g_pol
            assign ctrl[i].load_enable = ctrl_raw[i].load_enable ^ LOAD_INVERT[i];
            assign ctrl[i].clear = ctrl_raw[i].clear ^ CLEAR_INVERT[i];
        end
    endgenerate

    assign second_src = (SECOND_SOURCE == CHAIN_SOURCE) ? chained_operand_in : operand_two;

    // operand stage next values: clear outranks load
    always_comb begin
        operand_one_next = operand_one_reg;
        if (ctrl[STG_OP_ONE].clear) begin
            operand_one_next = OPERAND_RESET;
        end else if (ctrl[STG_OP_ONE].load_enable) begin
            operand_one_next = operand_one;
        end
        operand_two_next = operand_two_reg;
        if (ctrl[STG_OP_TWO].clear) begin
            operand_two_next = OPERAND_RESET;
        end else if (ctrl[STG_OP_TWO].load_enable) begin
            operand_two_next = second_src;
        end
    end

    always_ff @(posedge stage_clk or posedge sys_rst) begin
        if (sys_rst) begin
            operand_one_reg <= OPERAND_RESET;
            operand_two_reg <= OPERAND_RESET;
        end else begin
            operand_one_reg <= operand_one_next;
            operand_two_reg <= operand_two_next;
        end
    end

    // a bypassed stage leaves its flops in place but unread
    assign op_one_val = OPERAND_ONE_STAGE ? operand_one_reg : operand_one;
    assign op_two_val = OPERAND_TWO_STAGE ? operand_two_reg : second_src;

    // operands are taken as already sign-extended to full width
    assign mult_out = $signed(op_one_val) * $signed(op_two_val);

    // shift-and-add copy of the product, kept apart from the multiply operator so
    // that the product check cannot pass merely by repeating the expression
    logic signed [RES_W-1:0] ref_pp [OP_W];
    logic signed [RES_W-1:0] ref_acc [OP_W+1];
    logic signed [RES_W-1:0] ref_product;

    assign ref_acc[0] = '0;
    generate
        for (genvar b = 0; b < OP_W; b++) begin : g_ref
            // each set bit of the first operand below the top one adds the second, shifted into place
            assign ref_pp[b] = op_one_val[b] ? (RES_W'($signed(op_two_val)) <<< b) : '0;
            if (b == OP_W - 1) begin : g_top
                // the top bit of a two's complement word weighs negative
                assign ref_acc[b + 1] = ref_acc[b] - ref_pp[b];
            end else begin : g_low
                assign ref_acc[b + 1] = ref_acc[b] + ref_pp[b];
            end
        end
    endgenerate
    assign ref_product = ref_acc[OP_W];

    always_comb begin
        result_next = result_reg;
        if (ctrl[STG_RESULT].clear) begin
            result_next = RESULT_RESET;
        end else if (ctrl[STG_RESULT].load_enable) begin
            result_next = mult_out;
        end
    end

    always_ff @(posedge stage_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_reg <= RESULT_RESET;
        end else begin
            result_reg <= result_next;
        end
    end

    // bypass modes need a combinational path, so these outputs are not always flopped
    assign result_word = RESULT_STAGE ? result_reg : mult_out;
    assign chained_operand_out = op_two_val;

    default clocking cb @(posedge stage_clk);
    endclocking
    default disable iff (sys_rst);

    // first operand stage
    op_one_clear_a: assert property (
        ctrl[STG_OP_ONE].clear
        |=> operand_one_reg == OPERAND_RESET)
        else $error("first operand stage not cleared");
    op_one_load_a: assert property (
        ctrl[STG_OP_ONE].load_enable && !ctrl[STG_OP_ONE].clear
        |=> operand_one_reg == $past(operand_one))
        else $error("first operand stage did not load");
    op_one_hold_a: assert property (
        !ctrl[STG_OP_ONE].load_enable && !ctrl[STG_OP_ONE].clear
        |=> $stable(operand_one_reg))
        else $error("first operand stage changed without enable");
    // polarity is checked from the pins, so a wrong inversion cannot hide behind ctrl
    op_one_pol_a: assert property (
        (operand_one_clear ^ CLEAR_INVERT[STG_OP_ONE])
        |=> operand_one_reg == OPERAND_RESET)
        else $error("first operand clear polarity wrong");
    op_one_en_a: assert property (
        (operand_one_load_enable ^ LOAD_INVERT[STG_OP_ONE])
        && !(operand_one_clear ^ CLEAR_INVERT[STG_OP_ONE])
        |=> operand_one_reg == $past(operand_one))
        else $error("first operand enable polarity wrong");

    // second operand stage and the chained output
    op_two_clear_a: assert property (
        ctrl[STG_OP_TWO].clear
        |=> operand_two_reg == OPERAND_RESET)
        else $error("second operand stage not cleared");
    op_two_load_a: assert property (
        ctrl[STG_OP_TWO].load_enable && !ctrl[STG_OP_TWO].clear
        |=> operand_two_reg == $past(second_src))
        else $error("second operand stage did not load selected source");
    op_two_hold_a: assert property (
        !ctrl[STG_OP_TWO].load_enable && !ctrl[STG_OP_TWO].clear
        |=> $stable(operand_two_reg))
        else $error("second operand stage changed without enable");
    op_two_pol_a: assert property (
        (operand_two_clear ^ CLEAR_INVERT[STG_OP_TWO])
        |=> operand_two_reg == OPERAND_RESET)
        else $error("second operand clear polarity wrong");
    op_two_en_a: assert property (
        (operand_two_load_enable ^ LOAD_INVERT[STG_OP_TWO])
        && !(operand_two_clear ^ CLEAR_INVERT[STG_OP_TWO])
        |=> operand_two_reg == $past(second_src))
        else $error("second operand enable polarity wrong");
    chain_load_a: assert property (
        OPERAND_TWO_STAGE && ctrl[STG_OP_TWO].load_enable && !ctrl[STG_OP_TWO].clear
        |=> chained_operand_out == $past(second_src))
        else $error("staged chained output did not load");
    chain_staged_a: assert property (
        OPERAND_TWO_STAGE && !$stable(chained_operand_out)
        |-> $past(ctrl[STG_OP_TWO].load_enable) || $past(ctrl[STG_OP_TWO].clear))
        else $error("staged chained output moved without enable or clear");
    // the selection is static, so an unstaged chained output names its source directly
    chain_source_a: assert property (
        !OPERAND_TWO_STAGE && SECOND_SOURCE == CHAIN_SOURCE
        |-> chained_operand_out == chained_operand_in)
        else $error("chained output not taken from chain input");
    local_source_a: assert property (
        !OPERAND_TWO_STAGE && SECOND_SOURCE == LOCAL_SOURCE
        |-> chained_operand_out == operand_two)
        else $error("chained output not taken from local input");
    chain_out_a: assert property (
        chained_operand_out
        == (OPERAND_TWO_STAGE ? operand_two_reg : second_src))
        else $error("chained output differs from second multiplier input");

    // result stage and the result word in each stage mix
    res_clear_a: assert property (
        ctrl[STG_RESULT].clear
        |=> result_reg == RESULT_RESET)
        else $error("result stage not cleared");
    clear_wins_a: assert property (
        ctrl[STG_RESULT].clear && ctrl[STG_RESULT].load_enable
        |=> result_reg == RESULT_RESET)
        else $error("result load overrode clear");
    res_load_a: assert property (
        ctrl[STG_RESULT].load_enable && !ctrl[STG_RESULT].clear
        |=> result_reg == $past(ref_product))
        else $error("result stage did not load product");
    res_hold_a: assert property (
        !ctrl[STG_RESULT].load_enable && !ctrl[STG_RESULT].clear
        |=> $stable(result_reg))
        else $error("result stage changed without enable");
    res_pol_a: assert property (
        (result_clear ^ CLEAR_INVERT[STG_RESULT])
        |=> result_reg == RESULT_RESET)
        else $error("result clear polarity wrong");
    res_en_a: assert property (
        (result_load_enable ^ LOAD_INVERT[STG_RESULT])
        && !(result_clear ^ CLEAR_INVERT[STG_RESULT])
        |=> result_reg == $past(ref_product))
        else $error("result enable polarity wrong");
    result_word_a: assert property (
        RESULT_STAGE && !$stable(result_word)
        |-> $past(ctrl[STG_RESULT].load_enable) || $past(ctrl[STG_RESULT].clear))
        else $error("staged result moved without enable or clear");
    operands_only_a: assert property (
        !RESULT_STAGE && OPERAND_ONE_STAGE && OPERAND_TWO_STAGE && !$stable(result_word)
        |-> $past(ctrl[STG_OP_ONE].load_enable) || $past(ctrl[STG_OP_ONE].clear)
            || $past(ctrl[STG_OP_TWO].load_enable) || $past(ctrl[STG_OP_TWO].clear))
        else $error("result moved without an operand stage update");
    one_stage_a: assert property (
        !RESULT_STAGE && (OPERAND_ONE_STAGE != OPERAND_TWO_STAGE)
        |-> result_word == ref_product)
        else $error("single staged operand path gives wrong result");
    comb_path_a: assert property (
        !RESULT_STAGE && !OPERAND_ONE_STAGE && !OPERAND_TWO_STAGE
        |-> result_word == ref_product)
        else $error("bypassed result is not the product of raw inputs");
    product_value_a: assert property (
        1'b1
        |-> mult_out == ref_product)
        else $error("product is not the signed product");
    result_path_a: assert property (
        result_word
        == (RESULT_STAGE ? result_reg : mult_out))
        else $error("result word not from selected path");

    load_both_c: cover property (ctrl[STG_OP_ONE].load_enable && ctrl[STG_OP_TWO].load_enable
        ##1 ctrl[STG_RESULT].load_enable);
    clear_result_c: cover property (ctrl[STG_RESULT].clear && ctrl[STG_RESULT].load_enable);
    negative_product_c: cover property (ctrl[STG_RESULT].load_enable && mult_out < 0);
    clear_two_c: cover property (ctrl[STG_OP_TWO].clear && ctrl[STG_OP_ONE].load_enable);
    hold_all_c: cover property (!ctrl[STG_OP_ONE].load_enable && !ctrl[STG_OP_TWO].load_enable
        && $past(ctrl[STG_RESULT].load_enable) && !ctrl[STG_RESULT].load_enable);
endmodule : pipelined_signed_multiplier

/* fabric_operand_source.sv */
// user fabric model: widens narrow signed values to full operand width
`timescale 1ns/1ps
module fabric_operand_source
    import mult_pkg::*;
#(
    parameter int NARROW_W = 16
) (
    // narrow signed values
    input wire logic [NARROW_W-1:0] narrow_one,
    input wire logic [NARROW_W-1:0] narrow_two,
    // full-width operands
    output logic [OPERAND_W-1:0] wide_one,
    output logic [OPERAND_W-1:0] wide_two
);
    // msb replicated so the multiplier sees the same signed value
    assign wide_one = OPERAND_W'($signed(narrow_one));
    assign wide_two = OPERAND_W'($signed(narrow_two));
endmodule : fabric_operand_source

/* testbench.sv */
// self-checking bench for the multiplier in staged, single-stage and bypassed forms
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench
    import mult_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] narrow_one = 16'h0000;
    logic [15:0] narrow_two = 16'h0000;
    logic [OPERAND_W-1:0] wide_one;
    logic [OPERAND_W-1:0] wide_two;
    logic [OPERAND_W-1:0] chain_out;
    // chain input differs from every local value, so a wrong source shows
    logic [OPERAND_W-1:0] chain_in = 18'h2AAAA;
    stage_ctrl_t [STAGE_COUNT-1:0] ctl = 6'h00;
    logic [RESULT_W-1:0] result;
    logic [OPERAND_W-1:0] chain_comb;
    logic [RESULT_W-1:0] result_comb;
    logic [OPERAND_W-1:0] chain_raw;
    logic [RESULT_W-1:0] result_raw;
    // the single-stage copy takes every control active low
    stage_ctrl_t [STAGE_COUNT-1:0] ctl_n;
    int miscompares = 0;
    int samples_checked = 0;
    logic [15:0] tbl_one [4] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h1234};
    logic [15:0] tbl_two [4] = '{16'h8000, 16'h8001, 16'h7FFF, 16'hFEDC};

    fabric_operand_source u_src (.narrow_one(narrow_one), .narrow_two(narrow_two),
        .wide_one(wide_one), .wide_two(wide_two));
    pipelined_signed_multiplier u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .operand_one(wide_one), .operand_two(wide_two), .chained_operand_in(chain_in),
        .operand_one_load_enable(ctl[STG_OP_ONE].load_enable),
        .operand_one_clear(ctl[STG_OP_ONE].clear),
        .operand_two_load_enable(ctl[STG_OP_TWO].load_enable),
        .operand_two_clear(ctl[STG_OP_TWO].clear),
        .result_load_enable(ctl[STG_RESULT].load_enable),
        .result_clear(ctl[STG_RESULT].clear),
        .result_word(result), .chained_operand_out(chain_out));
    assign ctl_n = ~ctl;
    // first stage only, chained source: result follows the raw chain input
    pipelined_signed_multiplier #(.OPERAND_ONE_STAGE(1'b1), .OPERAND_TWO_STAGE(1'b0),
        .RESULT_STAGE(1'b0), .SECOND_SOURCE(CHAIN_SOURCE), .LOAD_INVERT(3'h7),
        .CLEAR_INVERT(3'h7)) u_dut_comb (.core_clk(core_clk), .sys_rst(sys_rst),
        .operand_one(wide_one), .operand_two(wide_two), .chained_operand_in(chain_in),
        .operand_one_load_enable(ctl_n[STG_OP_ONE].load_enable),
        .operand_one_clear(ctl_n[STG_OP_ONE].clear),
        .operand_two_load_enable(ctl_n[STG_OP_TWO].load_enable),
        .operand_two_clear(ctl_n[STG_OP_TWO].clear),
        .result_load_enable(ctl_n[STG_RESULT].load_enable),
        .result_clear(ctl_n[STG_RESULT].clear),
        .result_word(result_comb), .chained_operand_out(chain_comb));
    // every stage bypassed
    pipelined_signed_multiplier #(.OPERAND_ONE_STAGE(1'b0), .OPERAND_TWO_STAGE(1'b0),
        .RESULT_STAGE(1'b0)) u_dut_raw (.core_clk(core_clk), .sys_rst(sys_rst),
        .operand_one(wide_one), .operand_two(wide_two), .chained_operand_in(chain_in),
        .operand_one_load_enable(ctl[STG_OP_ONE].load_enable),
        .operand_one_clear(ctl[STG_OP_ONE].clear),
        .operand_two_load_enable(ctl[STG_OP_TWO].load_enable),
        .operand_two_clear(ctl[STG_OP_TWO].clear),
        .result_load_enable(ctl[STG_RESULT].load_enable),
        .result_clear(ctl[STG_RESULT].clear),
        .result_word(result_raw), .chained_operand_out(chain_raw));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // controls set at one edge act at the next and are dropped there, so each call
    // is exactly one stage update; outputs looked at on the falling edge after it
    task automatic drive(input logic [15:0] a, input logic [15:0] b, input logic [5:0] c);
        @(posedge core_clk);
        narrow_one <= a;
        narrow_two <= b;
        ctl <= c;
        @(posedge core_clk);
        ctl <= 6'h00;
        @(negedge core_clk);
    endtask : drive

    function automatic logic [RESULT_W-1:0] prod_w(input logic [OPERAND_W-1:0] a,
        input logic [OPERAND_W-1:0] b);
        logic signed [RESULT_W-1:0] e;
        e = $signed(a) * $signed(b);
        return e;
    endfunction : prod_w

    function automatic logic [RESULT_W-1:0] prod(input logic [15:0] a, input logic [15:0] b);
        logic signed [RESULT_W-1:0] e;
        e = $signed(a) * $signed(b);
        return e;
    endfunction : prod

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            repeat (3) drive(tbl_one[i], tbl_two[i], 6'h2A);
            `CHECK(chain_out, OPERAND_W'($signed(tbl_two[i])))
            `CHECK(result, prod(tbl_one[i], tbl_two[i]))
            `CHECK(result_comb, prod_w(OPERAND_W'($signed(tbl_one[i])), chain_in))
            `CHECK(chain_comb, chain_in)
            `CHECK(result_raw, prod(tbl_one[i], tbl_two[i]))
            `CHECK(chain_raw, OPERAND_W'($signed(tbl_two[i])))
        end
        $display("test products done");
        repeat (2) drive(16'h0101, 16'h0202, 6'h00);
        `CHECK(result, prod(tbl_one[3], tbl_two[3]))
        `CHECK(chain_out, OPERAND_W'($signed(tbl_two[3])))
        $display("test hold done");
        drive(16'h0101, 16'h0202, 6'h3A);
        `CHECK(result, 36'h000000000)
        drive(16'h0101, 16'h0202, 6'h2E);
        `CHECK(chain_out, 18'h00000)
        `CHECK(result, prod(16'h0101, 16'h0202))
        drive(16'h0101, 16'h0202, 6'h2B);
        drive(16'h0101, 16'h0202, 6'h2A);
        `CHECK(result, 36'h000000000)
        $display("test clears done");
        @(posedge core_clk);
        chain_in <= 18'h00003;
        @(negedge core_clk);
        `CHECK(result_comb, prod_w(18'h00101, 18'h00003))
        `CHECK(chain_comb, 18'h00003)
        `CHECK(result_raw, prod(16'h0101, 16'h0202))
        $display("test chain input done");
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(negedge core_clk);
        `CHECK(result, 36'h000000000)
        `CHECK(result_comb, 36'h000000000)
        `CHECK(chain_out, 18'h00000)
        $display("test reset done");
        tally_and_finish();
    end

    // whole run is well under a hundred cycles
    initial begin
        repeat (2000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : testbench
